// ==== inc/pdf_defs.svh ====
`ifndef PDF_DEFS_SVH
`define PDF_DEFS_SVH

// clock rate and timing
`define PDF_CLK_HZ 100000000
`define PDF_DETACH_TIME_MS 1000
`define PDF_DETACH_CYCLES ((`PDF_DETACH_TIME_MS * (`PDF_CLK_HZ / 1000)) + 1)
`define PDF_RESET_TIME_MS 100
`define PDF_RESET_CYCLES ((`PDF_RESET_TIME_MS * (`PDF_CLK_HZ / 1000)) + 1)
`define PDF_BLINK_TIME_MS 500
`define PDF_BLINK_CYCLES (`PDF_BLINK_TIME_MS * (`PDF_CLK_HZ / 1000))

// selection codes
`define PDF_SEL_0 5'h00
`define PDF_SEL_1 5'h01
`define PDF_SEL_2 5'h02
`define PDF_SEL_3 5'h03
`define PDF_SEL_14 5'h0E
`define PDF_SEL_15 5'h0F
`define PDF_SEL_16 5'h10
`define PDF_SEL_17 5'h11

// display codes
`define PDF_DISP_NONE 2'h0
`define PDF_DISP_DETACH 2'h1
`define PDF_DISP_REJ_A 2'h2
`define PDF_DISP_REJ_B 2'h3

`endif

// ==== inc/pdf_pkg.sv ====
package pdf_pkg;

    typedef enum logic [2:0] {
        PDF_RUN = 3'h1,
        PDF_FAULT = 3'h2,
        PDF_DETACH = 3'h4
    } pdf_state_t;

    typedef enum logic [1:0] {
        PDF_KEY_IDLE = 2'h1,
        PDF_KEY_READ = 2'h2
    } pdf_key_state_t;

    // decoded selection code
    typedef struct packed {
        logic valid;
        logic detach_trips;
        logic reset_only_fault;
        logic stop_key_on;
    } pdf_sel_t;

    // panel key pulses
    typedef struct packed {
        logic read_key;
        logic write_key;
        logic stop_key;
    } pdf_keys_t;

endpackage

// ==== src/pdf_persist.sv ====
`timescale 1ns/1ps
`include "pdf_defs.svh"

// counts how long a level has held; done once it has held for COUNT cycles
module pdf_persist #(
    parameter int COUNT = 100
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // level in
    input wire logic level,
    // result
    output logic done
);
    localparam int W = $clog2(COUNT + 1);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic done;
    } pdf_persist_st_t;

    pdf_persist_st_t st;
    pdf_persist_st_t next_st;

    initial
    begin
        if (COUNT < 1)
        begin
            $error("pdf_persist: COUNT must be at least 1");
        end
    end

    always_comb
    begin
        next_st = st;
        if (!level)
        begin
            next_st.cnt = '0;
            next_st.done = 1'b0;
        end
        else if (st.cnt != W'(COUNT))
        begin
            next_st.cnt = st.cnt + W'(1);
        end
        next_st.done = level && (next_st.cnt == W'(COUNT));
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign done = st.done;
endmodule

// ==== src/pdf_supervisor.sv ====
`timescale 1ns/1ps
`include "pdf_defs.svh"

module pdf_supervisor #(
    parameter int DETACH_CYCLES = `PDF_DETACH_CYCLES,
    parameter int RESET_CYCLES = `PDF_RESET_CYCLES,
    parameter int BLINK_CYCLES = `PDF_BLINK_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // configuration
    input wire logic [4:0] reset_and_detach_select,
    // operator panel pins
    input wire logic operator_panel_present,
    input wire logic operator_panel_read_key,
    input wire logic operator_panel_write_key,
    input wire logic operator_panel_stop_key,
    // reset contact, high while closed to contact_common_terminal
    input wire logic reset_contact_terminal,
    // other protective trips from the drive
    input wire logic protect_trip,
    // drive control
    output logic output_enable,
    output logic stop_request,
    output logic alarm_led,
    output logic [1:0] display_code,
    // reset effects
    output logic reset_pulse,
    output logic clear_thermal,
    output logic clear_retry
);
    localparam int BW = $clog2(BLINK_CYCLES + 1);

    typedef struct packed {
        logic [1:0] sync_present;
        logic [1:0] sync_contact;
        logic [1:0] sync_read;
        logic [1:0] sync_write;
        logic [1:0] sync_stop;
        pdf_pkg::pdf_keys_t keys_prev;
        pdf_pkg::pdf_state_t state;
        pdf_pkg::pdf_key_state_t key_state;
        logic armed;
        logic contact_qualified;
        logic stopped;
        logic reject;
        logic reject_phase;
        logic [BW-1:0] blink_cnt;
        logic reset_pulse;
        logic [1:0] display_code;
    } pdf_sup_st_t;

    pdf_sup_st_t st;
    pdf_sup_st_t next_st;
    pdf_pkg::pdf_sel_t sel;
    pdf_pkg::pdf_keys_t keys_now;
    pdf_pkg::pdf_keys_t keys_rise;
    logic absent_long;
    logic contact_long;

    initial
    begin
        if (DETACH_CYCLES < 1 || RESET_CYCLES < 1 || BLINK_CYCLES < 1)
        begin
            $error("pdf_supervisor: cycle counts must be at least 1");
        end
    end

    // absence timer restarts on reconnect
    pdf_persist #(
        .COUNT(DETACH_CYCLES)
    ) u_absent (
        .mclk(mclk),
        .resetn(resetn),
        .level(st.armed && !st.sync_present[1]),
        .done(absent_long)
    );

    // contact closure qualification
    pdf_persist #(
        .COUNT(RESET_CYCLES)
    ) u_contact (
        .mclk(mclk),
        .resetn(resetn),
        .level(st.sync_contact[1]),
        .done(contact_long)
    );

    always_comb
    begin
        sel = '0;
        case (reset_and_detach_select)
            `PDF_SEL_0: sel = '{1'b1, 1'b0, 1'b0, 1'b0};
            `PDF_SEL_1: sel = '{1'b1, 1'b0, 1'b1, 1'b0};
            `PDF_SEL_2: sel = '{1'b1, 1'b1, 1'b0, 1'b0};
            `PDF_SEL_3: sel = '{1'b1, 1'b1, 1'b1, 1'b0};
            `PDF_SEL_14: sel = '{1'b1, 1'b0, 1'b0, 1'b1};
            `PDF_SEL_15: sel = '{1'b1, 1'b0, 1'b1, 1'b1};
            `PDF_SEL_16: sel = '{1'b1, 1'b1, 1'b0, 1'b1};
            `PDF_SEL_17: sel = '{1'b1, 1'b1, 1'b1, 1'b1};
            default: sel = '0;
        endcase
    end

    assign keys_now = '{st.sync_read[1], st.sync_write[1], st.sync_stop[1]};
    assign keys_rise = keys_now & ~st.keys_prev;

    always_comb
    begin
        logic faulted;
        logic allowed;
        logic panel_req;
        logic term_req;
        logic do_reset;
        faulted = 1'b0;
        allowed = 1'b0;
        panel_req = 1'b0;
        term_req = 1'b0;
        do_reset = 1'b0;
        next_st = st;
        next_st.sync_present = {st.sync_present[0], operator_panel_present};
        next_st.sync_contact = {st.sync_contact[0], reset_contact_terminal};
        next_st.sync_read = {st.sync_read[0], operator_panel_read_key};
        next_st.sync_write = {st.sync_write[0], operator_panel_write_key};
        next_st.sync_stop = {st.sync_stop[0], operator_panel_stop_key};
        next_st.keys_prev = keys_now;
        next_st.reset_pulse = 1'b0;

        faulted = (st.state != pdf_pkg::PDF_RUN) || protect_trip;
        allowed = !sel.reset_only_fault || faulted;

        // only a panel seen present arms detection
        if (st.sync_present[1])
        begin
            next_st.armed = 1'b1;
        end

        // qualified closure fires on release only
        if (contact_long)
        begin
            next_st.contact_qualified = 1'b1;
        end
        if (!st.sync_contact[1])
        begin
            next_st.contact_qualified = 1'b0;
        end
        term_req = st.contact_qualified && !st.sync_contact[1];

        // read then write sequence
        case (st.key_state)
            pdf_pkg::PDF_KEY_IDLE:
            begin
                if (keys_rise.read_key)
                begin
                    next_st.key_state = pdf_pkg::PDF_KEY_READ;
                end
            end
            pdf_pkg::PDF_KEY_READ:
            begin
                if (keys_rise.write_key)
                begin
                    panel_req = 1'b1;
                    next_st.key_state = pdf_pkg::PDF_KEY_IDLE;
                end
            end
            default: next_st.key_state = pdf_pkg::PDF_KEY_IDLE;
        endcase
        // write alone in idle falls through unused

        if (keys_rise.stop_key && faulted)
        begin
            panel_req = 1'b1;
        end

        if (panel_req)
        begin
            if (allowed && sel.reset_only_fault)
            begin
                do_reset = 1'b1;
            end
            else
            begin
                next_st.reject = 1'b1;
                next_st.blink_cnt = '0;
                next_st.reject_phase = 1'b0;
            end
        end
        if (term_req && allowed)
        begin
            do_reset = 1'b1;
        end

        // stop key stops motor under codes 14-17
        if (keys_rise.stop_key && sel.stop_key_on && !faulted)
        begin
            next_st.stopped = 1'b1;
        end

        if (st.reject)
        begin
            if (st.blink_cnt == BW'(BLINK_CYCLES - 1))
            begin
                next_st.blink_cnt = '0;
                next_st.reject_phase = !st.reject_phase;
            end
            else
            begin
                next_st.blink_cnt = st.blink_cnt + BW'(1);
            end
        end

        case (st.state)
            pdf_pkg::PDF_RUN:
            begin
                if (absent_long && sel.detach_trips)
                begin
                    next_st.state = pdf_pkg::PDF_DETACH;
                end
            end
            pdf_pkg::PDF_FAULT, pdf_pkg::PDF_DETACH:
            begin
                if (do_reset)
                begin
                    next_st.state = pdf_pkg::PDF_RUN;
                end
            end
            default: next_st.state = pdf_pkg::PDF_RUN;
        endcase
        if (protect_trip && !do_reset && st.state == pdf_pkg::PDF_RUN)
        begin
            next_st.state = pdf_pkg::PDF_FAULT;
        end

        if (do_reset)
        begin
            next_st.reset_pulse = 1'b1;
            next_st.stopped = 1'b0;
            next_st.reject = 1'b0;
            next_st.armed = st.sync_present[1];
        end

        if (next_st.state == pdf_pkg::PDF_DETACH)
        begin
            next_st.display_code = `PDF_DISP_DETACH;
        end
        else if (next_st.reject)
        begin
            next_st.display_code = next_st.reject_phase ? `PDF_DISP_REJ_B : `PDF_DISP_REJ_A;
        end
        else
        begin
            next_st.display_code = `PDF_DISP_NONE;
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st <= '0;
            st.state <= pdf_pkg::PDF_RUN;
            st.key_state <= pdf_pkg::PDF_KEY_IDLE;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign output_enable = (st.state == pdf_pkg::PDF_RUN) && !st.stopped;
    assign stop_request = st.stopped;
    assign alarm_led = (st.state == pdf_pkg::PDF_DETACH);
    assign display_code = st.display_code;
    assign reset_pulse = st.reset_pulse;
    assign clear_thermal = st.reset_pulse;
    assign clear_retry = st.reset_pulse;
endmodule

// ==== test/pdf_supervisor_checker.sv ====
`timescale 1ns/1ps
`include "pdf_defs.svh"

module pdf_supervisor_checker #(
    parameter int DETACH_CYCLES = `PDF_DETACH_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // watched pins
    input wire logic [4:0] reset_and_detach_select,
    input wire logic operator_panel_present,
    input wire logic output_enable,
    input wire logic stop_request,
    input wire logic alarm_led,
    input wire logic [1:0] display_code,
    input wire logic reset_pulse,
    input wire logic clear_thermal,
    input wire logic clear_retry
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    // raw pin absence run length
    int absent_cnt;
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            absent_cnt <= 0;
        else if (operator_panel_present)
            absent_cnt <= 0;
        else if (absent_cnt < 1000000)
            absent_cnt <= absent_cnt + 1;
    end

    AST_TRIP_CODE: assert property ($rose(alarm_led) |-> reset_and_detach_select inside {5'h02, 5'h03, 5'h10, 5'h11})
        else $error("detach alarm under a non-trip code");
    AST_ALARM_OFF: assert property (alarm_led |-> !output_enable)
        else $error("output on during detach alarm");
    AST_DISPLAY: assert property ($rose(alarm_led) |-> ##[0:2] display_code == `PDF_DISP_DETACH)
        else $error("detach code not shown");
    AST_PERSIST: assert property ($rose(alarm_led) |-> absent_cnt >= DETACH_CYCLES)
        else $error("detach declared too early");
    AST_HOLD: assert property ($fell(alarm_led) |-> ##[0:1] (reset_pulse || $past(reset_pulse) || $past(reset_pulse, 2)))
        else $error("detach alarm left without reset");
    AST_PULSE: assert property (reset_pulse |-> clear_thermal && clear_retry ##1 !reset_pulse)
        else $error("reset pulse malformed");
    AST_CLEAR: assert property ((clear_thermal || clear_retry) |-> reset_pulse)
        else $error("clear without reset");
    AST_STOP_CODE: assert property ($rose(stop_request) |-> reset_and_detach_select inside {5'h0E, 5'h0F, 5'h10, 5'h11})
        else $error("stop key acted under codes 0 to 3");
    AST_STOP_OFF: assert property (stop_request |-> !output_enable)
        else $error("output on while stopped");
endmodule

bind pdf_supervisor pdf_supervisor_checker #(.DETACH_CYCLES(DETACH_CYCLES)) i_pdf_supervisor_checker (
    .mclk(mclk), .resetn(resetn), .reset_and_detach_select(reset_and_detach_select),
    .operator_panel_present(operator_panel_present), .output_enable(output_enable),
    .stop_request(stop_request), .alarm_led(alarm_led), .display_code(display_code),
    .reset_pulse(reset_pulse), .clear_thermal(clear_thermal), .clear_retry(clear_retry)
);

// ==== test/pdf_panel_model.sv ====
`timescale 1ns/1ps

module pdf_panel_model (
    // clock
    input wire logic mclk,
    // panel and contact pins
    output logic present,
    output pdf_pkg::pdf_keys_t keys,
    output logic contact
);
    initial
    begin
        present = 1'b0;
        keys = 3'h0;
        contact = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // bench restores the panel before resets until test_mid_reset leaves it absent
    task automatic set_present(input logic on);
        tick(1);
        present = on;
    endtask

    task automatic press(input pdf_pkg::pdf_keys_t k);
        tick(1);
        keys = k;
        tick(4);
        keys = 3'h0;
        tick(4);
    endtask

    // closed for n cycles, then opened
    task automatic close_contact(input int n);
        tick(1);
        contact = 1'b1;
        tick(n);
        contact = 1'b0;
        tick(1);
    endtask
endmodule

// ==== test/pdf_supervisor_bench.sv ====
`timescale 1ns/1ps
`include "pdf_defs.svh"

module pdf_supervisor_bench;
    localparam int DET = 50;
    localparam int RST = 10;
    localparam pdf_pkg::pdf_keys_t RD = 3'h4;
    localparam pdf_pkg::pdf_keys_t WR = 3'h2;
    localparam pdf_pkg::pdf_keys_t STP = 3'h1;
    localparam pdf_pkg::pdf_keys_t NONE = 3'h0;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [4:0] sel = 5'h00;
    logic protect_trip = 1'b0;
    logic output_enable, stop_request, alarm_led, reset_pulse, clear_thermal, clear_retry, present, contact;
    logic [1:0] display_code;
    pdf_pkg::pdf_keys_t keys;
    logic [7:0] pulses = 8'h00;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;

    always #5 mclk = ~mclk;

    pdf_supervisor #(.DETACH_CYCLES(DET), .RESET_CYCLES(RST), .BLINK_CYCLES(4)) i_pdf_supervisor (
        .mclk(mclk), .resetn(resetn), .reset_and_detach_select(sel), .operator_panel_present(present),
        .operator_panel_read_key(keys.read_key), .operator_panel_write_key(keys.write_key),
        .operator_panel_stop_key(keys.stop_key), .reset_contact_terminal(contact), .protect_trip(protect_trip),
        .output_enable(output_enable), .stop_request(stop_request), .alarm_led(alarm_led),
        .display_code(display_code), .reset_pulse(reset_pulse), .clear_thermal(clear_thermal),
        .clear_retry(clear_retry)
    );
    pdf_panel_model i_pdf_panel_model (.mclk(mclk), .present(present), .keys(keys), .contact(contact));

    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (reset_pulse === 1'b1)
            pulses <= pulses + 8'h01;
        if (cycles == 8000)
        begin
            fails++;
            test_done();
        end
    end

    task automatic test_done();
        if (fails == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic term_reset(input int n, input logic [7:0] exp);
        logic [7:0] p;
        p = pulses;
        i_pdf_panel_model.close_contact(n);
        cyc(8);
        check(pulses - p, exp);
    endtask

    task automatic key_reset(input pdf_pkg::pdf_keys_t a, input pdf_pkg::pdf_keys_t b, input logic [7:0] exp);
        logic [7:0] p;
        p = pulses;
        i_pdf_panel_model.press(a);
        if (b != NONE)
            i_pdf_panel_model.press(b);
        cyc(8);
        check(pulses - p, exp);
    endtask

    task automatic test_detach_codes();
        logic [4:0] codes [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h0E, 5'h0F, 5'h10, 5'h11};
        logic trip;
        logic any;
        sel = 5'h02;
        cyc(DET + 20);
        check(8'(alarm_led), 8'h00);
        foreach (codes[i])
        begin
            sel = codes[i];
            trip = codes[i] inside {5'h02, 5'h03, 5'h10, 5'h11};
            any = codes[i] inside {5'h00, 5'h02, 5'h0E, 5'h10};
            i_pdf_panel_model.set_present(1'b1);
            cyc(5);
            i_pdf_panel_model.set_present(1'b0);
            cyc(DET + 10);
            check(8'(alarm_led), 8'(trip));
            check(8'(output_enable), 8'(!trip));
            if (trip)
                check(8'(display_code), 8'(`PDF_DISP_DETACH));
            i_pdf_panel_model.set_present(1'b1);
            cyc(20);
            check(8'(alarm_led), 8'(trip));
            term_reset(RST + 3, 8'(trip | any));
            check(8'(alarm_led), 8'h00);
        end
    endtask

    task automatic test_short_events();
        sel = 5'h02;
        repeat (2)
        begin
            i_pdf_panel_model.set_present(1'b0);
            cyc(DET - 10);
            i_pdf_panel_model.set_present(1'b1);
            cyc(5);
        end
        check(8'(alarm_led), 8'h00);
        sel = 5'h00;
        term_reset(3, 8'h00);
    endtask

    // mid-run reset drops a detach trip; an absent panel must not re-arm
    task automatic test_mid_reset();
        sel = 5'h10;
        i_pdf_panel_model.set_present(1'b1);
        cyc(5);
        i_pdf_panel_model.set_present(1'b0);
        cyc(DET + 10);
        check(8'(alarm_led), 8'h01);
        resetn = 1'b0;
        cyc(3);
        check({4'h0, display_code, alarm_led, output_enable}, 8'h01);
        resetn = 1'b1;
        cyc(DET + 10);
        check({6'h00, alarm_led, output_enable}, 8'h01);
    endtask

    task automatic test_panel_keys();
        logic [1:0] seen;
        seen = 2'h0;
        sel = 5'h00;
        key_reset(RD, WR, 8'h00);
        repeat (16)
        begin
            cyc(1);
            if (display_code === `PDF_DISP_REJ_A)
                seen[1] = 1'b1;
            if (display_code === `PDF_DISP_REJ_B)
                seen[0] = 1'b1;
        end
        check(8'(seen), 8'h03);
        sel = 5'h01;
        protect_trip = 1'b1;
        key_reset(WR, RD, 8'h00);
        key_reset(WR, NONE, 8'h01);
        protect_trip = 1'b0;
        // fault state outlives the trip input until a reset
        term_reset(RST + 3, 8'h01);
        key_reset(RD, WR, 8'h00);
    endtask

    task automatic test_stop_key();
        sel = 5'h00;
        key_reset(STP, NONE, 8'h00);
        check({6'h00, stop_request, output_enable}, 8'h01);
        sel = 5'h0E;
        key_reset(STP, NONE, 8'h00);
        check({6'h00, stop_request, output_enable}, 8'h02);
        term_reset(RST + 3, 8'h01);
        check(8'(stop_request), 8'h00);
        sel = 5'h0F;
        protect_trip = 1'b1;
        key_reset(STP, NONE, 8'h01);
        check(8'(stop_request), 8'h00);
        protect_trip = 1'b0;
    endtask

    initial
    begin
        repeat (16) @(posedge mclk);
        #1;
        resetn = 1'b1;
        cyc(4);
        test_detach_codes();
        test_short_events();
        test_mid_reset();
        test_panel_keys();
        test_stop_key();
        test_done();
    end
endmodule
